// file: src/ccm_consts.svh
// Address map, reset values and layout constants of the channel mode block
//
// Overview of operation
// RL1 - Direction 00 makes an output; 01 own input; 10 neighbouring input.
// RL2 - Direction 11 captures from the selected internal trigger input.
// RL3 - Direction changes only while the channel enable is low.
// RL4 - Filter code sits in bits 7:4, used only for input channels.
// RL5 - Prescaler sits in bits 3:2, used only for input channels.
// RL6 - Fast enable bit 2, preload bit 3, used only for output channels.
// RL7 - Compare fields act on outputs only; capture fields on inputs only.
// RL8 - Non-direction bits are read by the current direction of the channel.
// RL9 - Each timer has its own channel three/four mode register, reset zero.
// RL10 - Filter code picks sample rate and count N; 0000 passes unfiltered.
// RL11 - Prescaler captures every edge, every 2, 4 or 8 events.
// RL12 - Compare mode: frozen, set, clear, toggle, force, two PWM modes.
// RL13 - Preload buffers compare writes until update event; else immediate.
// RL14 - Bits 31:16 read zero and ignore writes.
`ifndef CCM_CONSTS_SVH
`define CCM_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define CCM_T1_MODE_ADDR 32'h4000e01c
`define CCM_T2_MODE_ADDR 32'h4000f01c
`define CCM_T1_CMP3_ADDR 32'h4000e03c
`define CCM_T1_CMP4_ADDR 32'h4000e040
`define CCM_T2_CMP3_ADDR 32'h4000f03c
`define CCM_T2_CMP4_ADDR 32'h4000f040

// ----------------------------------------------------------------------
// Reset values and layout
// ----------------------------------------------------------------------
`define CCM_MODE_RESET 8'h00
`define CCM_CMP_RESET 16'h0000
`define CCM_BYTE_W 8
`define CCM_REG_LOW_W 16
`define CCM_PRELOAD_BIT 1
`define CCM_FAST_BIT 0
`define CCM_RATE_N 6

`endif

// file: src/ccm_pkg.sv
// Types shared by the channel mode block
package ccm_pkg;

	typedef enum logic [1:0] {
		CCM_DIR_OUT = 2'h0,
		CCM_DIR_OWN = 2'h1,
		CCM_DIR_NEIGH = 2'h2,
		CCM_DIR_TRIG = 2'h3
	} ccm_dir_t;

	typedef enum logic [2:0] {
		CCM_OC_FROZEN = 3'h0,
		CCM_OC_SET = 3'h1,
		CCM_OC_CLEAR = 3'h2,
		CCM_OC_TOGGLE = 3'h3,
		CCM_OC_FORCE_LOW = 3'h4,
		CCM_OC_FORCE_HIGH = 3'h5,
		CCM_OC_PWM1 = 3'h6,
		CCM_OC_PWM2 = 3'h7
	} ccm_ocm_t;

	// One channel byte: upper is filter or {0, compare mode},
	// middle is prescaler or {preload, fast}
	typedef struct packed {
		logic [3:0] upper;
		logic [1:0] middle;
		ccm_dir_t dir;
	} ccm_mode_t;

	// Filter decode: sample rate index (divide by 2**rate) and count N
	typedef struct packed {
		logic [2:0] rate;
		logic [3:0] count;
	} ccm_filt_t;

	// Per-timer signals from the counter and slave logic
	typedef struct packed {
		logic count_down;
		logic update_event;
		logic internal_trigger_input;
	} ccm_tmr_t;

endpackage

// file: src/ccm_input_cond.sv
// Input filter, edge detect and event prescaler of one capture channel
`include "ccm_consts.svh"

module ccm_input_cond
	import ccm_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Sample enables, bit k pulses once every 2**k clocks
	input wire logic [`CCM_RATE_N-1:0] sample_en_in,
	// Selected capture source, already in this clock domain
	input wire logic sig_in,
	// Settings
	input wire logic active_in,
	input wire logic [3:0] filter_in,
	input wire logic [1:0] prescaler_in,
	// Capture request
	output logic capture_out
);

	// ------------------------------------------------------------------
	// Filter code decode
	// ------------------------------------------------------------------
	function automatic ccm_filt_t filt_decode(input logic [3:0] code);
		ccm_filt_t f;
		f = '{rate: 3'h0, count: 4'h1};
		unique case (code)
			4'h0: f = '{rate: 3'h0, count: 4'h1};
			4'h1: f = '{rate: 3'h0, count: 4'h2};
			4'h2: f = '{rate: 3'h0, count: 4'h4};
			4'h3: f = '{rate: 3'h1, count: 4'h6};
			4'h4: f = '{rate: 3'h1, count: 4'h6};
			4'h5: f = '{rate: 3'h2, count: 4'h6};
			4'h6: f = '{rate: 3'h2, count: 4'h6};
			4'h7: f = '{rate: 3'h3, count: 4'h8};
			4'h8: f = '{rate: 3'h3, count: 4'h8};
			4'h9: f = '{rate: 3'h3, count: 4'h8};
			4'ha: f = '{rate: 3'h4, count: 4'h5};
			4'hb: f = '{rate: 3'h4, count: 4'h6};
			4'hc: f = '{rate: 3'h4, count: 4'h6};
			4'hd: f = '{rate: 3'h4, count: 4'h8};
			4'he: f = '{rate: 3'h5, count: 4'h6};
			4'hf: f = '{rate: 3'h5, count: 4'h8};
		endcase
		return f;
	endfunction

	logic filt_ff, nxt_filt;
	logic [3:0] run_ff, nxt_run;
	logic prev_ff, nxt_prev;
	logic [2:0] psc_ff, nxt_psc;
	logic cap_ff, nxt_cap;

	assign capture_out = cap_ff;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		ccm_filt_t f;
		logic edge_seen;
		logic [2:0] mask;
		f = filt_decode(filter_in);
		edge_seen = filt_ff & ~prev_ff;
		mask = 3'h0;
		nxt_filt = filt_ff;
		nxt_run = run_ff;
		nxt_prev = filt_ff;
		nxt_psc = psc_ff;
		nxt_cap = 1'b0;
		// Output flips only after N samples in a row disagree with it
		if (filter_in == 4'h0) begin
			nxt_filt = sig_in; // RL10
			nxt_run = 4'h0;
		end else if (sample_en_in[f.rate]) begin
			if (sig_in == filt_ff) begin
				nxt_run = 4'h0;
			end else if (run_ff + 4'h1 >= f.count) begin
				nxt_filt = sig_in; // RL10
				nxt_run = 4'h0;
			end else begin
				nxt_run = run_ff + 4'h1;
			end
		end
		unique case (prescaler_in)
			2'h0: mask = 3'h0; // RL11
			2'h1: mask = 3'h1;
			2'h2: mask = 3'h3;
			2'h3: mask = 3'h7;
		endcase
		if (!active_in) begin
			nxt_psc = 3'h0; // RL5
		end else if (edge_seen) begin
			nxt_cap = (psc_ff & mask) == mask; // RL11
			nxt_psc = (psc_ff + 3'h1) & mask;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			filt_ff <= 1'b0;
			run_ff <= 4'h0;
			prev_ff <= 1'b0;
			psc_ff <= 3'h0;
			cap_ff <= 1'b0;
		end else begin
			filt_ff <= nxt_filt;
			run_ff <= nxt_run;
			prev_ff <= nxt_prev;
			psc_ff <= nxt_psc;
			cap_ff <= nxt_cap;
		end
	end

endmodule

// file: src/ccm_mode_cfg.sv
// Channel three/four mode registers, compare and capture of two timers
//
// Chosen here: strobed register access.
`include "ccm_consts.svh"

module ccm_mode_cfg
	import ccm_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Register port
	input wire logic [31:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Timer side, index is the timer
	input wire logic [1:0][CNT_W-1:0] counter_in,
	input wire ccm_tmr_t [1:0] tmr_in,
	// Channel side, index is timer*2 + (channel-3)
	input wire logic [3:0] ch_channel_enable_in,
	input wire logic [3:0] timer_input_in,
	output logic [3:0] compare_reference_out,
	output logic [3:0] capture_event_out,
	output logic [3:0] chan_is_input_out
);

	// Compare values live in the low half of a register word
	if (CNT_W < 1 || CNT_W > `CCM_REG_LOW_W) begin : g_bad_cnt_w
		$error("CNT_W must lie between 1 and 16");
	end

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// Returns a one-hot channel for a compare address, zero otherwise
	function automatic logic [3:0] cmp_hit(input logic [31:0] a);
		cmp_hit = {a == `CCM_T2_CMP4_ADDR, a == `CCM_T2_CMP3_ADDR,
			a == `CCM_T1_CMP4_ADDR, a == `CCM_T1_CMP3_ADDR};
	endfunction

	// Returns a one-hot timer for a mode register address
	function automatic logic [1:0] mode_hit(input logic [31:0] a);
		mode_hit = {a == `CCM_T2_MODE_ADDR, a == `CCM_T1_MODE_ADDR};
	endfunction

	// ------------------------------------------------------------------
	// Field helpers
	// ------------------------------------------------------------------
	// Active level of PWM mode 1; mode 2 is its inverse
	function automatic logic pwm_active(input logic down,
		input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp);
		if (down) begin
			pwm_active = cnt <= cmp;
		end else begin
			pwm_active = cnt < cmp;
		end
	endfunction

	// Packs the two channel bytes of one timer, upper half reads zero
	function automatic logic [31:0] mode_word(input ccm_mode_t lo,
		input ccm_mode_t hi);
		mode_word = {16'h0000, hi, lo}; // RL14
	endfunction

	// Byte kept by a mode write: a locked channel keeps its direction,
	// and bit 7 of an output channel has no field and stays zero
	function automatic ccm_mode_t wr_byte(input ccm_mode_t cur,
		input ccm_mode_t req, input logic locked);
		wr_byte = req;
		if (locked) begin
			wr_byte.dir = cur.dir; // RL3
		end
		if (wr_byte.dir == CCM_DIR_OUT) begin
			wr_byte.upper[3] = 1'b0; // RL14
		end
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	ccm_mode_t mode_ff [4];
	ccm_mode_t nxt_mode [4];
	logic [CNT_W-1:0] buf_ff [4];
	logic [CNT_W-1:0] nxt_buf [4];
	logic [CNT_W-1:0] act_ff [4];
	logic [CNT_W-1:0] nxt_act [4];
	logic [3:0] ref_ff, nxt_ref;
	logic [3:0] cap_ff, nxt_cap;
	logic [3:0] in_ff, nxt_in;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [`CCM_RATE_N-2:0] div_ff, nxt_div;
	logic [3:0] sync1_ff, nxt_sync1;
	logic [3:0] sync2_ff, nxt_sync2;
	logic [`CCM_RATE_N-1:0] sample_en;
	logic [3:0] src_sel;
	logic [3:0] cap_req;

	assign reg_rdata_out = rdata_ff;
	assign compare_reference_out = ref_ff;
	assign capture_event_out = cap_ff;
	assign chan_is_input_out = in_ff;

	// ------------------------------------------------------------------
	// Pin synchroniser and sample rate divider
	// ------------------------------------------------------------------
	// The first flop is read by the second one only
	always_comb begin
		nxt_sync1 = timer_input_in;
		nxt_sync2 = sync1_ff;
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end

	// Enable k is high when the low k divider bits are all ones
	always_comb begin
		nxt_div = div_ff + 5'h01;
		sample_en[0] = 1'b1;
		for (int k = 1; k < `CCM_RATE_N; k++) begin
			sample_en[k] = sample_en[k-1] & div_ff[k-1];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			div_ff <= 5'h00;
		end else begin
			div_ff <= nxt_div;
		end
	end

	// ------------------------------------------------------------------
	// Capture source selection and conditioning
	// ------------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			unique case (mode_ff[i].dir)
				CCM_DIR_OUT: src_sel[i] = 1'b0; // RL1
				CCM_DIR_OWN: src_sel[i] = sync2_ff[i]; // RL1
				CCM_DIR_NEIGH: src_sel[i] = sync2_ff[i^1]; // RL1
				CCM_DIR_TRIG: src_sel[i] =
					tmr_in[i/2].internal_trigger_input; // RL2
			endcase
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_chan
		ccm_input_cond u_cond (
			.clk_sys_in(clk_sys_in),
			.sys_rst_in(sys_rst_in),
			.sample_en_in(sample_en),
			.sig_in(src_sel[g]),
			.active_in(mode_ff[g].dir != CCM_DIR_OUT), // RL7
			.filter_in(mode_ff[g].upper), // RL4
			.prescaler_in(mode_ff[g].middle), // RL5
			.capture_out(cap_req[g])
		);
	end

	// ------------------------------------------------------------------
	// Mode registers, compare values and reference outputs
	// ------------------------------------------------------------------
	always_comb begin
		ccm_mode_t wm;
		logic out_mode;
		logic preload;
		logic fast;
		logic hit;
		logic lvl;
		logic [CNT_W-1:0] cnt;
		logic [1:0] mh;
		logic [3:0] ch;
		wm = '0;
		out_mode = 1'b0;
		preload = 1'b0;
		fast = 1'b0;
		hit = 1'b0;
		lvl = 1'b0;
		cnt = '0;
		mh = mode_hit(reg_addr_in);
		ch = cmp_hit(reg_addr_in);
		for (int i = 0; i < 4; i++) begin
			cnt = counter_in[i/2];
			nxt_mode[i] = mode_ff[i];
			nxt_buf[i] = buf_ff[i];
			nxt_act[i] = act_ff[i];
			// Only the low 16 bits are stored
			if (reg_wr_in && mh[i/2]) begin
				wm = reg_wdata_in[(i%2)*`CCM_BYTE_W +: `CCM_BYTE_W]; // RL14
				nxt_mode[i] = wr_byte(mode_ff[i], wm, // RL9
					ch_channel_enable_in[i]);
			end
			out_mode = mode_ff[i].dir == CCM_DIR_OUT; // RL8
			preload = out_mode && mode_ff[i].middle[`CCM_PRELOAD_BIT]; // RL6
			fast = out_mode && mode_ff[i].middle[`CCM_FAST_BIT]; // RL6
			if (reg_wr_in && ch[i]) begin
				nxt_buf[i] = reg_wdata_in[CNT_W-1:0];
				if (!preload) begin
					nxt_act[i] = reg_wdata_in[CNT_W-1:0]; // RL13
				end
			end
			if (preload && tmr_in[i/2].update_event) begin
				nxt_act[i] = buf_ff[i]; // RL13
			end
			// A capture wins over a software write in the same cycle
			if (!out_mode && cap_req[i]) begin
				nxt_buf[i] = cnt; // RL7
				nxt_act[i] = cnt;
			end
			hit = cnt == act_ff[i];
			lvl = ref_ff[i];
			unique case (ccm_ocm_t'(mode_ff[i].upper[2:0])) // RL12
				CCM_OC_FROZEN: lvl = ref_ff[i];
				CCM_OC_SET: lvl = hit ? 1'b1 : ref_ff[i];
				CCM_OC_CLEAR: lvl = hit ? 1'b0 : ref_ff[i];
				CCM_OC_TOGGLE: lvl = hit ? ~ref_ff[i] : ref_ff[i];
				CCM_OC_FORCE_LOW: lvl = 1'b0;
				CCM_OC_FORCE_HIGH: lvl = 1'b1;
				CCM_OC_PWM1: begin
					lvl = pwm_active(tmr_in[i/2].count_down, cnt,
						act_ff[i]);
					if (fast && tmr_in[i/2].internal_trigger_input) begin
						lvl = 1'b0; // RL6
					end
				end
				CCM_OC_PWM2: begin
					lvl = !pwm_active(tmr_in[i/2].count_down, cnt,
						act_ff[i]);
					if (fast && tmr_in[i/2].internal_trigger_input) begin
						lvl = 1'b1; // RL6
					end
				end
			endcase
			nxt_ref[i] = out_mode ? lvl : 1'b0; // RL7
			nxt_cap[i] = !out_mode && cap_req[i];
			nxt_in[i] = !out_mode;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < 4; i++) begin
				mode_ff[i] <= `CCM_MODE_RESET; // RL9
				buf_ff[i] <= CNT_W'(`CCM_CMP_RESET);
				act_ff[i] <= CNT_W'(`CCM_CMP_RESET);
			end
			ref_ff <= 4'h0;
			cap_ff <= 4'h0;
			in_ff <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				mode_ff[i] <= nxt_mode[i];
				buf_ff[i] <= nxt_buf[i];
				act_ff[i] <= nxt_act[i];
			end
			ref_ff <= nxt_ref;
			cap_ff <= nxt_cap;
			in_ff <= nxt_in;
		end
	end

	// ------------------------------------------------------------------
	// Read path, data valid in the cycle after the strobe only
	// ------------------------------------------------------------------
	always_comb begin
		logic [1:0] mh;
		logic [3:0] ch;
		mh = mode_hit(reg_addr_in);
		ch = cmp_hit(reg_addr_in);
		nxt_rdata = 32'h0000_0000;
		if (reg_rd_in) begin
			if (mh[0]) begin
				nxt_rdata = mode_word(mode_ff[0], mode_ff[1]); // RL14
			end else if (mh[1]) begin
				nxt_rdata = mode_word(mode_ff[2], mode_ff[3]); // RL14
			end
			for (int i = 0; i < 4; i++) begin
				if (ch[i]) begin
					nxt_rdata = 32'(buf_ff[i]);
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

endmodule

// file: testbench/ccm_mode_cfg_sva.sv
// Port checker of the channel mode block
`include "ccm_consts.svh"
module ccm_mode_cfg_chk
	import ccm_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Register port
	input wire logic [31:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// Timer and channel side
	input wire logic [1:0][CNT_W-1:0] counter_in,
	input wire ccm_tmr_t [1:0] tmr_in,
	input wire logic [3:0] ch_channel_enable_in,
	input wire logic [3:0] timer_input_in,
	input wire logic [3:0] compare_reference_out,
	input wire logic [3:0] capture_event_out,
	input wire logic [3:0] chan_is_input_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	logic w1;
	logic mapped;
	assign w1 = reg_wr_in && reg_addr_in == `CCM_T1_MODE_ADDR;
	assign mapped = reg_addr_in inside {`CCM_T1_MODE_ADDR, `CCM_T2_MODE_ADDR,
		`CCM_T1_CMP3_ADDR, `CCM_T1_CMP4_ADDR, `CCM_T2_CMP3_ADDR,
		`CCM_T2_CMP4_ADDR};
	a_rst_quiet: assert property ($past(sys_rst_in) |->
		!compare_reference_out && !capture_event_out && !chan_is_input_out
		&& !reg_rdata_out) else $error("outputs not clear after reset");
	a_rd_upper_zero: assert property (
		reg_rdata_out[31:16] == 16'h0000) else $error("upper read bits set");
	a_rd_unmapped: assert property (reg_rd_in && !mapped |=>
		reg_rdata_out == 32'h0000_0000) else $error("unmapped read data");
	a_ref_out_only: assert property (
		(compare_reference_out & chan_is_input_out) == 4'h0)
		else $error("compare reference on input channel");
	a_cap_in_only: assert property (
		(capture_event_out & ~chan_is_input_out) == 4'h0)
		else $error("capture on output channel");
	a_cap_one_cycle: assert property (
		capture_event_out[0] |=> !capture_event_out[0])
		else $error("capture pulse too long");
	a_dir_set_two: assert property (w1 && !ch_channel_enable_in[0] |->
		##2 chan_is_input_out[0] == ($past(reg_wdata_in[1:0], 2) != 2'h0))
		else $error("direction not applied");
	a_dir_locked: assert property (ch_channel_enable_in[0] &&
		$past(ch_channel_enable_in[0]) && $past(ch_channel_enable_in[0], 2)
		|-> $stable(chan_is_input_out[0])) else $error("direction moved");
	c_capture: cover property (capture_event_out[0]);
	c_reference: cover property (compare_reference_out[0]);
	c_locked_wr: cover property (w1 && ch_channel_enable_in[0]);
endmodule

// file: testbench/ccm_pin_model.sv
// Model of the capture pins in front of the timer channels
module ccm_pin_model (
	// Clock
	input wire logic clk_sys_in,
	// Pins
	output logic [3:0] pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin_out = 4'h0;
	// Pulses change on the falling edge, away from the sampling edge
	task automatic pulse(input int i, input int hi, input int lo);
		@(negedge clk_sys_in);
		pin_out[i] = 1'b1;
		repeat (hi) @(negedge clk_sys_in);
		pin_out[i] = 1'b0;
		repeat (lo) @(negedge clk_sys_in);
	endtask
endmodule

// file: testbench/ccm_mode_cfg_tb.sv
// Self-checking bench of the channel mode block
`include "ccm_consts.svh"
module ccm_mode_cfg_tb
	import ccm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] m1 = `CCM_T1_MODE_ADDR;
	localparam logic [31:0] m2 = `CCM_T2_MODE_ADDR;
	localparam logic [31:0] k3 = `CCM_T1_CMP3_ADDR;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] a = 32'h0;
	logic [31:0] wd = 32'h0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [31:0] rdat;
	logic [1:0][15:0] cnt = 32'h0;
	ccm_tmr_t [1:0] tm = 6'h00;
	logic [3:0] en = 4'h0;
	logic [3:0] pin;
	logic [3:0] ref_o;
	logic [3:0] cap;
	logic [3:0] isin;
	logic [31:0] d;
	logic [15:0] c;
	logic [15:0] p;
	int seed = 32'h99b4;
	int err_total = 0;
	int compares = 0;
	int ncap = 0;
	int n0;
	always #50 clk = ~clk;
	always @(posedge clk) if (cap[0] === 1'b1) ncap <= ncap + 1;
	ccm_pin_model i_pins (.clk_sys_in(clk), .pin_out(pin));
	ccm_mode_cfg #(.CNT_W(16)) i_dut (.clk_sys_in(clk), .sys_rst_in(rst),
		.reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(we), .reg_rd_in(re),
		.reg_rdata_out(rdat), .counter_in(cnt), .tmr_in(tm),
		.ch_channel_enable_in(en), .timer_input_in(pin),
		.compare_reference_out(ref_o), .capture_event_out(cap),
		.chan_is_input_out(isin));
	// ----
	// Bus tasks and expectations
	// ----
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [31:0] ad, input logic [31:0] v);
		@(posedge clk);
		a <= ad;
		wd <= v;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] ad, input logic [31:0] e);
		@(posedge clk);
		a <= ad;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		@(posedge clk);
		chk(rdat, e);
	endtask
	task automatic gap(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [31:0] msk(input logic [31:0] v);
		msk = {16'h0, v[15:0]};
		if (v[1:0] == 2'h0) msk[7] = 1'b0;
		if (v[9:8] == 2'h0) msk[15] = 1'b0;
	endfunction
	function automatic logic [1:0] dirs(input logic [31:0] v);
		dirs = {v[9:8] != 2'h0, v[1:0] != 2'h0};
	endfunction
	function automatic logic pwm(input int m, input logic dn,
		input logic [15:0] x, y);
		case (m)
			4: pwm = 1'b0;
			5: pwm = 1'b1;
			6: pwm = dn ? x <= y : x < y;
			default: pwm = dn ? x > y : !(x < y);
		endcase
	endfunction
	task automatic test_done;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		gap(5);
		rst <= 1'b0;
		rd(m1, 32'h0);
		rd(m2, 32'h0);
		repeat (16) begin
			d = $random(seed);
			wr(m1, d);
			rd(m1, msk(d));
			wr(m2, ~d);
			rd(m2, msk(~d));
			chk(32'(isin), 32'({dirs(~d), dirs(d)}));
		end
		rd(32'h4000e020, 32'h0);
		wr(m2, 32'h5040);
		wr(m1, 32'h4040);
		gap(3);
		chk(32'(ref_o), 32'h8);
		en <= 4'h1;
		wr(m1, 32'h0031);
		rd(m1, 32'h0030);
		en <= 4'h0;
		for (int k = 0; k < 2; k++) begin
			c = 16'($random(seed));
			p = k ? c : 16'($random(seed));
			tm[0].count_down <= 1'(k);
			cnt[0] <= c;
			wr(k3, {16'h0, p});
			for (int m = 4; m < 8; m++) begin
				wr(m1, 32'(m << 4));
				gap(3);
				chk(32'(ref_o[0]), 32'(pwm(m, 1'(k), c, p)));
			end
		end
		cnt[0] <= 16'h0064;
		tm[0].count_down <= 1'b0;
		wr(k3, 32'h0);
		wr(m1, 32'h0068);
		wr(k3, 32'h00c8);
		gap(3);
		chk(32'(ref_o[0]), 32'h0);
		rd(k3, 32'h00c8);
		tm[0].update_event <= 1'b1;
		gap(1);
		tm[0].update_event <= 1'b0;
		gap(3);
		chk(32'(ref_o[0]), 32'h1);
		wr(m1, 32'h64);
		tm[0].internal_trigger_input <= 1'b1;
		gap(3);
		chk(32'(ref_o[0]), 32'h0);
		tm[0].internal_trigger_input <= 1'b0;
		gap(3);
		chk(32'(ref_o[0]), 32'h1);
		cnt[0] <= 16'h00c8;
		wr(m1, 32'h40);
		gap(3);
		chk(32'(ref_o[0]), 32'h0);
		wr(m1, 32'h10);
		gap(3);
		chk(32'(ref_o[0]), 32'h1);
		wr(m1, 32'h20);
		gap(3);
		chk(32'(ref_o[0]), 32'h0);
		cnt[0] <= 16'h0064;
		wr(m1, 32'h30);
		gap(3);
		chk(32'(ref_o[0]), 32'h0);
		cnt[0] <= 16'h00c8;
		gap(1);
		cnt[0] <= 16'h0064;
		wr(m1, 32'h0);
		gap(3);
		chk(32'(ref_o[0]), 32'h1);
		cnt[0] <= 16'h0123;
		for (int s = 0; s < 4; s++) begin
			wr(m1, 32'h1 | 32'(s << 2));
			n0 = ncap;
			repeat (8) i_pins.pulse(0, 3, 3);
			gap(10);
			chk(32'(ncap - n0), 32'(8 >> s));
		end
		rd(k3, 32'h0123);
		wr(m1, 32'h2);
		n0 = ncap;
		i_pins.pulse(1, 3, 3);
		i_pins.pulse(0, 3, 3);
		gap(10);
		chk(32'(ncap - n0), 32'h1);
		wr(m1, 32'h3);
		n0 = ncap;
		tm[0].internal_trigger_input <= 1'b1;
		gap(10);
		tm[0].internal_trigger_input <= 1'b0;
		chk(32'(ncap - n0), 32'h1);
		wr(m1, 32'h11);
		n0 = ncap;
		i_pins.pulse(0, 1, 8);
		chk(32'(ncap - n0), 32'h0);
		i_pins.pulse(0, 4, 10);
		chk(32'(ncap - n0), 32'h1);
		gap(1);
		rst <= 1'b1;
		gap(2);
		rst <= 1'b0;
		rd(m1, 32'h0);
		rd(m2, 32'h0);
		test_done;
	end
	initial begin
		#2000000;
		err_total++;
		test_done;
	end
endmodule
bind ccm_mode_cfg ccm_mode_cfg_chk #(.CNT_W(CNT_W)) i_chk (.clk_sys_in,
	.sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .counter_in, .tmr_in, .ch_channel_enable_in,
	.timer_input_in, .compare_reference_out, .capture_event_out,
	.chan_is_input_out);
